/* File: pkg/abx_map.svh */
// Constants of the execute unit: flag positions, cycle counts, masks
// What this block does
// RQ1: Add registers, optional carry, flags ZCNVH, one cycle
// RQ2: Word add/subtract immediate, two cycles, flags ZCNVS
// RQ3: Subtract register/constant and carry, one cycle, ZCNVH
// RQ4: Subtract constant from register, one cycle, ZCNVH
// RQ5: AND/OR/XOR in one cycle, carry untouched
// RQ6: Set mask ORs immediate, flags Z N V
// RQ7: Clear mask ANDs with 0xFF minus mask
// RQ8: Test ANDs register with itself, value unchanged
// RQ9: Integer multiplies write product pair, two cycles
// RQ10: Fractional multiplies shift product left one, two cycles
// RQ11: Pointer jump loads PC from Z, two cycles
// RQ12: Pointer call pushes return, loads Z, three cycles
// RQ13: Equal skip advances PC 2 or 3, 1/2/3 cycles
// RQ14: Compares set flags, store nothing, one cycle
// RQ15: Bit skips test a register bit, 1/2/3 cycles
// RQ16: Relative/absolute jump 2/3, relative/absolute call 3/4
// RQ17: Returns take four cycles; interrupt return sets I
`ifndef ABX_MAP_SVH
`define ABX_MAP_SVH
`define ABX_FLAG_C 0
`define ABX_FLAG_Z 1
`define ABX_FLAG_N 2
`define ABX_FLAG_V 3
`define ABX_FLAG_S 4
`define ABX_FLAG_H 5
`define ABX_FLAG_I 7
`define ABX_SREG_RST 8'h00
`define ABX_BYTE_ONES 8'hFF
`define ABX_CYC_ONE 3'h1
`define ABX_CYC_TWO 3'h2
`define ABX_CYC_THREE 3'h3
`define ABX_CYC_FOUR 3'h4
`define ABX_PC_STEP1 16'h0001
`define ABX_PC_STEP2 16'h0002
`define ABX_PC_STEP3 16'h0003
`endif

/* File: pkg/abx_pkg.sv */
// Types shared by the execute unit: operations, states, destinations
package abx_pkg;
  typedef enum logic [5:0] {
    OP_ADD_REG, OP_ADD_CARRY, OP_MINUS_REG, OP_MINUS_CONSTANT,
    OP_MINUS_WITH_BORROW, OP_MINUS_BORROW_CONSTANT,
    OP_WORD_ADD_IMMEDIATE, OP_WORD_MINUS_IMMEDIATE,
    OP_CONJUNCTION_REG, OP_CONJUNCTION_CONSTANT,
    OP_DISJUNCTION_REG, OP_DISJUNCTION_CONSTANT,
    OP_EXCLUSIVE_DISJUNCTION, OP_BIT_SET_MASK, OP_BIT_CLEAR_MASK,
    OP_ZERO_MINUS_TEST,
    OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT, OP_MIXED_SIGN_PRODUCT,
    OP_FRACTION_PRODUCT_UNSIGNED, OP_FRACTION_PRODUCT_SIGNED,
    OP_FRACTION_PRODUCT_MIXED,
    OP_RELATIVE_JUMP, OP_POINTER_JUMP, OP_ABSOLUTE_JUMP,
    OP_RELATIVE_SUBCALL, OP_POINTER_CALL, OP_ABSOLUTE_SUBCALL,
    OP_SUBROUTINE_BACK, OP_INTERRUPT_BACK,
    OP_EQUAL_SKIP, OP_REG_COMPARE, OP_REG_COMPARE_CARRY,
    OP_IMMEDIATE_COMPARE, OP_SKIP_ON_BIT_LOW, OP_SKIP_ON_BIT_HIGH
  } abx_op_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } abx_state_t;
  typedef enum logic [1:0] {
    DST_REG = 2'h0,
    DST_WORD = 2'h1,
    DST_PROD = 2'h2
  } abx_dst_t;
endpackage

/* File: hdl/abx_addsub.sv */
// Eight-bit adder/subtractor with carry, half-carry and overflow
`timescale 1ns/1ps
`default_nettype none
module abx_addsub (
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  input wire logic cin_i,
  input wire logic sub_i,
  output logic [7:0] r_o,
  output logic c_o,
  output logic h_o,
  output logic v_o
);
  logic [8:0] sum;
  // Borrow on subtract is the ninth bit of the wrapped difference
  always_comb begin
    if (sub_i) begin
      sum = {1'b0, a_i} - {1'b0, b_i} - {8'h00, cin_i};
    end else begin
      sum = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin_i};
    end
  end
  assign r_o = sum[7:0];
  assign c_o = sum[8];
  // Half carry and overflow follow the textbook bit equations
  always_comb begin
    if (sub_i) begin
      h_o = (~a_i[3] & b_i[3]) | (b_i[3] & r_o[3]) | (r_o[3] & ~a_i[3]);
      v_o = (a_i[7] & ~b_i[7] & ~r_o[7]) | (~a_i[7] & b_i[7] & r_o[7]);
    end else begin
      h_o = (a_i[3] & b_i[3]) | (b_i[3] & ~r_o[3]) | (~r_o[3] & a_i[3]);
      v_o = (a_i[7] & b_i[7] & ~r_o[7]) | (~a_i[7] & ~b_i[7] & r_o[7]);
    end
  end
endmodule
`default_nettype wire

/* File: hdl/abx_mult.sv */
// Eight by eight multiplier with sign selection and fractional shift
`timescale 1ns/1ps
`default_nettype none
module abx_mult (
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  input wire logic a_sgn_i,
  input wire logic b_sgn_i,
  input wire logic frac_i,
  output logic [15:0] prod_o,
  output logic c_o
);
  logic signed [8:0] ax;
  logic signed [8:0] bx;
  logic signed [17:0] full;
  logic [15:0] raw;
  // A ninth bit extends each operand as signed or unsigned
  assign ax = $signed({a_sgn_i & a_i[7], a_i});
  assign bx = $signed({b_sgn_i & b_i[7], b_i});
  assign full = ax * bx;
  assign raw = full[15:0];
  // Carry is the top bit before the fractional shift
  assign c_o = raw[15];
  assign prod_o = frac_i ? {raw[14:0], 1'b0} : raw;
endmodule
`default_nettype wire

/* File: hdl/abx_exec_unit.sv */
// Execute unit: arithmetic, logic, multiply and control-flow operations
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "abx_map.svh"
module abx_exec_unit (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic op_valid_i,
  input wire abx_pkg::abx_op_t op_i,
  input wire logic [7:0] rd_val_i,
  input wire logic [7:0] rr_val_i,
  input wire logic [7:0] imm_i,
  input wire logic [2:0] bit_sel_i,
  input wire logic [15:0] word_i,
  input wire logic [15:0] z_ptr_i,
  input wire logic [15:0] pc_i,
  input wire logic [15:0] k_i,
  input wire logic [15:0] stack_pc_i,
  input wire logic next_two_word_i,
  output logic busy_o,
  output logic done_o,
  output logic [15:0] res_o,
  output logic res_we_o,
  output abx_pkg::abx_dst_t res_dst_o,
  output logic [7:0] sreg_o,
  output logic [15:0] pc_o,
  output logic pc_we_o,
  output logic push_o,
  output logic [15:0] push_addr_o
);
  abx_pkg::abx_state_t state_r;
  logic [2:0] cnt_r;
  logic acc;
  logic [7:0] opb;
  logic as_sub;
  logic as_cin;
  logic [7:0] as_r;
  logic as_c;
  logic as_h;
  logic as_v;
  logic m_asgn;
  logic m_bsgn;
  logic m_frac;
  logic [15:0] m_prod;
  logic m_c;
  logic [16:0] wsum;
  logic [7:0] lg;
  logic skip;
  // Combined next values of one operation
  logic [15:0] res_nxt;
  logic we_nxt;
  abx_pkg::abx_dst_t dst_nxt;
  logic [7:0] sreg_nxt;
  logic [15:0] pc_nxt;
  logic pcwe_nxt;
  logic push_nxt;
  logic [15:0] paddr_nxt;
  logic [2:0] cyc_nxt;
  // Held copies for multi-cycle operations
  logic [15:0] p_res_r;
  logic p_we_r;
  abx_pkg::abx_dst_t p_dst_r;
  logic [7:0] p_sreg_r;
  logic [15:0] p_pc_r;
  logic p_pcwe_r;
  logic p_push_r;
  logic [15:0] p_paddr_r;

  // A new operation is taken only while no earlier one is running
  assign acc = op_valid_i && (state_r == abx_pkg::ST_IDLE);
  assign busy_o = state_r[1];

  // Operand B is the constant for immediate forms, 0xFF minus it for clear mask
  always_comb begin
    unique case (op_i)
      abx_pkg::OP_MINUS_CONSTANT, abx_pkg::OP_MINUS_BORROW_CONSTANT,
      abx_pkg::OP_CONJUNCTION_CONSTANT, abx_pkg::OP_DISJUNCTION_CONSTANT,
      abx_pkg::OP_BIT_SET_MASK, abx_pkg::OP_IMMEDIATE_COMPARE:
        opb = imm_i;
      abx_pkg::OP_BIT_CLEAR_MASK:
        opb = `ABX_BYTE_ONES - imm_i; // RQ7
      default:
        opb = rr_val_i;
    endcase
  end

  // Adder mode and carry-in
  assign as_sub = !(op_i inside {abx_pkg::OP_ADD_REG,
                                 abx_pkg::OP_ADD_CARRY});
  assign as_cin = sreg_o[`ABX_FLAG_C] &
                  (op_i inside {abx_pkg::OP_ADD_CARRY,
                                abx_pkg::OP_MINUS_WITH_BORROW,
                                abx_pkg::OP_MINUS_BORROW_CONSTANT,
                                abx_pkg::OP_REG_COMPARE_CARRY});

  abx_addsub u_addsub (
    .a_i(rd_val_i),
    .b_i(opb),
    .cin_i(as_cin),
    .sub_i(as_sub),
    .r_o(as_r),
    .c_o(as_c),
    .h_o(as_h),
    .v_o(as_v)
  );

  // Sign selection for the six multiply forms
  assign m_asgn = op_i inside {abx_pkg::OP_SIGNED_PRODUCT,
                               abx_pkg::OP_MIXED_SIGN_PRODUCT,
                               abx_pkg::OP_FRACTION_PRODUCT_SIGNED,
                               abx_pkg::OP_FRACTION_PRODUCT_MIXED};
  assign m_bsgn = op_i inside {abx_pkg::OP_SIGNED_PRODUCT,
                               abx_pkg::OP_FRACTION_PRODUCT_SIGNED};
  assign m_frac = op_i inside {abx_pkg::OP_FRACTION_PRODUCT_UNSIGNED,
                               abx_pkg::OP_FRACTION_PRODUCT_SIGNED,
                               abx_pkg::OP_FRACTION_PRODUCT_MIXED};

  abx_mult u_mult (
    .a_i(rd_val_i),
    .b_i(rr_val_i),
    .a_sgn_i(m_asgn),
    .b_sgn_i(m_bsgn),
    .frac_i(m_frac),
    .prod_o(m_prod),
    .c_o(m_c)
  );

  // Word arithmetic on the register pair, immediate zero-extended
  always_comb begin
    if (op_i == abx_pkg::OP_WORD_MINUS_IMMEDIATE) begin
      wsum = {1'b0, word_i} - {9'h000, imm_i};
    end else begin
      wsum = {1'b0, word_i} + {9'h000, imm_i};
    end
  end

  // Logic result and skip condition
  always_comb begin
    unique case (op_i)
      abx_pkg::OP_DISJUNCTION_REG, abx_pkg::OP_DISJUNCTION_CONSTANT,
      abx_pkg::OP_BIT_SET_MASK:
        lg = rd_val_i | opb; // RQ6
      abx_pkg::OP_EXCLUSIVE_DISJUNCTION:
        lg = rd_val_i ^ opb;
      abx_pkg::OP_ZERO_MINUS_TEST:
        lg = rd_val_i & rd_val_i; // RQ8
      default:
        lg = rd_val_i & opb; // RQ7
    endcase
  end

  always_comb begin
    unique case (op_i)
      abx_pkg::OP_EQUAL_SKIP: skip = (rd_val_i == rr_val_i); // RQ13
      abx_pkg::OP_SKIP_ON_BIT_LOW: skip = !rr_val_i[bit_sel_i]; // RQ15
      abx_pkg::OP_SKIP_ON_BIT_HIGH: skip = rr_val_i[bit_sel_i]; // RQ15
      default: skip = 1'b0;
    endcase
  end

  // Per-operation outcome; flags not named by an operation keep value
  always_comb begin
    res_nxt = {8'h00, as_r};
    we_nxt = 1'b0;
    dst_nxt = abx_pkg::DST_REG;
    sreg_nxt = sreg_o;
    pc_nxt = pc_i;
    pcwe_nxt = 1'b0;
    push_nxt = 1'b0;
    paddr_nxt = pc_i + `ABX_PC_STEP1;
    cyc_nxt = `ABX_CYC_ONE;
    unique case (op_i)
      abx_pkg::OP_ADD_REG, abx_pkg::OP_ADD_CARRY,
      abx_pkg::OP_MINUS_REG, abx_pkg::OP_MINUS_CONSTANT,
      abx_pkg::OP_MINUS_WITH_BORROW, abx_pkg::OP_MINUS_BORROW_CONSTANT,
      abx_pkg::OP_REG_COMPARE, abx_pkg::OP_REG_COMPARE_CARRY,
      abx_pkg::OP_IMMEDIATE_COMPARE: begin
        // Compares leave the destination alone
        we_nxt = !(op_i inside {abx_pkg::OP_REG_COMPARE,
                                abx_pkg::OP_REG_COMPARE_CARRY,
                                abx_pkg::OP_IMMEDIATE_COMPARE}); // RQ14
        sreg_nxt[`ABX_FLAG_C] = as_c; // RQ1 RQ3 RQ4
        sreg_nxt[`ABX_FLAG_H] = as_h;
        sreg_nxt[`ABX_FLAG_V] = as_v;
        sreg_nxt[`ABX_FLAG_N] = as_r[7];
        // Borrow forms chain zero across bytes of a wide subtract
        if (as_sub && (op_i inside {abx_pkg::OP_MINUS_WITH_BORROW,
                                   abx_pkg::OP_MINUS_BORROW_CONSTANT,
                                   abx_pkg::OP_REG_COMPARE_CARRY})) begin
          sreg_nxt[`ABX_FLAG_Z] = (as_r == 8'h00) &
                                  sreg_o[`ABX_FLAG_Z]; // RQ3
        end else begin
          sreg_nxt[`ABX_FLAG_Z] = (as_r == 8'h00);
        end
      end
      abx_pkg::OP_WORD_ADD_IMMEDIATE,
      abx_pkg::OP_WORD_MINUS_IMMEDIATE: begin
        res_nxt = wsum[15:0]; // RQ2
        we_nxt = 1'b1;
        dst_nxt = abx_pkg::DST_WORD;
        cyc_nxt = `ABX_CYC_TWO;
        sreg_nxt[`ABX_FLAG_Z] = (wsum[15:0] == 16'h0000);
        sreg_nxt[`ABX_FLAG_N] = wsum[15];
        sreg_nxt[`ABX_FLAG_C] = wsum[16];
        if (op_i == abx_pkg::OP_WORD_ADD_IMMEDIATE) begin
          sreg_nxt[`ABX_FLAG_V] = !word_i[15] & wsum[15];
        end else begin
          sreg_nxt[`ABX_FLAG_V] = word_i[15] & !wsum[15];
        end
        sreg_nxt[`ABX_FLAG_S] = sreg_nxt[`ABX_FLAG_N] ^
                                sreg_nxt[`ABX_FLAG_V];
      end
      abx_pkg::OP_CONJUNCTION_REG, abx_pkg::OP_CONJUNCTION_CONSTANT,
      abx_pkg::OP_DISJUNCTION_REG, abx_pkg::OP_DISJUNCTION_CONSTANT,
      abx_pkg::OP_EXCLUSIVE_DISJUNCTION, abx_pkg::OP_BIT_SET_MASK,
      abx_pkg::OP_BIT_CLEAR_MASK, abx_pkg::OP_ZERO_MINUS_TEST: begin
        // Carry and half carry stay as they were
        res_nxt = {8'h00, lg}; // RQ5
        we_nxt = 1'b1;
        sreg_nxt[`ABX_FLAG_Z] = (lg == 8'h00);
        sreg_nxt[`ABX_FLAG_N] = lg[7];
        sreg_nxt[`ABX_FLAG_V] = 1'b0;
      end
      abx_pkg::OP_UNSIGNED_PRODUCT, abx_pkg::OP_SIGNED_PRODUCT,
      abx_pkg::OP_MIXED_SIGN_PRODUCT,
      abx_pkg::OP_FRACTION_PRODUCT_UNSIGNED,
      abx_pkg::OP_FRACTION_PRODUCT_SIGNED,
      abx_pkg::OP_FRACTION_PRODUCT_MIXED: begin
        res_nxt = m_prod; // RQ9 RQ10
        we_nxt = 1'b1;
        dst_nxt = abx_pkg::DST_PROD;
        cyc_nxt = `ABX_CYC_TWO;
        sreg_nxt[`ABX_FLAG_Z] = (m_prod == 16'h0000);
        sreg_nxt[`ABX_FLAG_C] = m_c;
      end
      abx_pkg::OP_RELATIVE_JUMP, abx_pkg::OP_RELATIVE_SUBCALL: begin
        pc_nxt = pc_i + k_i + `ABX_PC_STEP1; // RQ16
        pcwe_nxt = 1'b1;
        push_nxt = (op_i == abx_pkg::OP_RELATIVE_SUBCALL);
        cyc_nxt = push_nxt ? `ABX_CYC_THREE : `ABX_CYC_TWO;
      end
      abx_pkg::OP_ABSOLUTE_JUMP, abx_pkg::OP_ABSOLUTE_SUBCALL: begin
        // Absolute forms are two words long; return past both
        pc_nxt = k_i; // RQ16
        pcwe_nxt = 1'b1;
        push_nxt = (op_i == abx_pkg::OP_ABSOLUTE_SUBCALL);
        paddr_nxt = pc_i + `ABX_PC_STEP2;
        cyc_nxt = push_nxt ? `ABX_CYC_FOUR : `ABX_CYC_THREE;
      end
      abx_pkg::OP_POINTER_JUMP, abx_pkg::OP_POINTER_CALL: begin
        pc_nxt = z_ptr_i; // RQ11 RQ12
        pcwe_nxt = 1'b1;
        push_nxt = (op_i == abx_pkg::OP_POINTER_CALL);
        cyc_nxt = push_nxt ? `ABX_CYC_THREE : `ABX_CYC_TWO;
      end
      abx_pkg::OP_SUBROUTINE_BACK, abx_pkg::OP_INTERRUPT_BACK: begin
        pc_nxt = stack_pc_i; // RQ17
        pcwe_nxt = 1'b1;
        cyc_nxt = `ABX_CYC_FOUR;
        if (op_i == abx_pkg::OP_INTERRUPT_BACK) begin
          sreg_nxt[`ABX_FLAG_I] = 1'b1; // RQ17
        end
      end
      default: begin
        // Skips: one cycle when not taken, else by next length
        pcwe_nxt = skip;
        pc_nxt = pc_i + (next_two_word_i ? `ABX_PC_STEP3
                                         : `ABX_PC_STEP2); // RQ13 RQ15
        if (skip) begin
          cyc_nxt = next_two_word_i ? `ABX_CYC_THREE : `ABX_CYC_TWO;
        end
      end
    endcase
  end

  // Sequencer: idle, or counting down the remaining cycles
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= abx_pkg::ST_IDLE;
      cnt_r <= 3'h0;
    end else begin
      unique case (state_r)
        abx_pkg::ST_IDLE: begin
          if (acc && (cyc_nxt != `ABX_CYC_ONE)) begin
            state_r <= abx_pkg::ST_BUSY;
            cnt_r <= cyc_nxt - `ABX_CYC_ONE;
          end
        end
        abx_pkg::ST_BUSY: begin
          cnt_r <= cnt_r - `ABX_CYC_ONE;
          if (cnt_r == `ABX_CYC_ONE) begin
            state_r <= abx_pkg::ST_IDLE;
          end
        end
        default: begin
          state_r <= abx_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Multi-cycle results are held until their last cycle
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      p_res_r <= 16'h0000;
      p_we_r <= 1'b0;
      p_dst_r <= abx_pkg::DST_REG;
      p_sreg_r <= `ABX_SREG_RST;
      p_pc_r <= 16'h0000;
      p_pcwe_r <= 1'b0;
      p_push_r <= 1'b0;
      p_paddr_r <= 16'h0000;
    end else if (acc) begin
      p_res_r <= res_nxt;
      p_we_r <= we_nxt;
      p_dst_r <= dst_nxt;
      p_sreg_r <= sreg_nxt;
      p_pc_r <= pc_nxt;
      p_pcwe_r <= pcwe_nxt;
      p_push_r <= push_nxt;
      p_paddr_r <= paddr_nxt;
    end
  end

  // Publish at the end of the last cycle; flags change only then,
  // so a following operation always sees settled flags
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
      res_o <= 16'h0000;
      res_we_o <= 1'b0;
      res_dst_o <= abx_pkg::DST_REG;
      sreg_o <= `ABX_SREG_RST;
      pc_o <= 16'h0000;
      pc_we_o <= 1'b0;
      push_o <= 1'b0;
      push_addr_o <= 16'h0000;
    end else if (acc && (cyc_nxt == `ABX_CYC_ONE)) begin
      done_o <= 1'b1;
      res_o <= res_nxt;
      res_we_o <= we_nxt;
      res_dst_o <= dst_nxt;
      sreg_o <= sreg_nxt;
      pc_o <= pc_nxt;
      pc_we_o <= pcwe_nxt;
      push_o <= 1'b0;
    end else if (state_r[1] && (cnt_r == `ABX_CYC_ONE)) begin
      done_o <= 1'b1;
      res_o <= p_res_r;
      res_we_o <= p_we_r;
      res_dst_o <= p_dst_r;
      sreg_o <= p_sreg_r;
      pc_o <= p_pc_r;
      pc_we_o <= p_pcwe_r;
      push_o <= p_push_r;
      push_addr_o <= p_paddr_r;
    end else begin
      done_o <= 1'b0;
      res_we_o <= 1'b0;
      pc_we_o <= 1'b0;
      push_o <= 1'b0;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_add_result: assert property ( // RQ1
    acc && op_i == abx_pkg::OP_ADD_REG |=> done_o && res_we_o &&
      res_o[7:0] == $past(rd_val_i) + $past(rr_val_i))
    else $error("add result wrong");
  a_word_two: assert property ( // RQ2
    acc && op_i == abx_pkg::OP_WORD_ADD_IMMEDIATE |=> !done_o ##1
      done_o && res_dst_o == abx_pkg::DST_WORD &&
      res_o == $past(word_i, 2) + {8'h00, $past(imm_i, 2)})
    else $error("word add wrong");
  a_minus_const: assert property ( // RQ4
    acc && op_i == abx_pkg::OP_MINUS_CONSTANT |=> done_o &&
      res_o[7:0] == $past(rd_val_i) - $past(imm_i) &&
      sreg_o[`ABX_FLAG_C] == ($past(imm_i) > $past(rd_val_i)))
    else $error("constant subtract wrong");
  a_logic_carry: assert property ( // RQ5
    acc && op_i == abx_pkg::OP_EXCLUSIVE_DISJUNCTION |=>
      $stable(sreg_o[`ABX_FLAG_C]) && !sreg_o[`ABX_FLAG_V])
    else $error("logic op disturbed carry");
  a_clear_mask: assert property ( // RQ7
    acc && op_i == abx_pkg::OP_BIT_CLEAR_MASK |=>
      res_o[7:0] == ($past(rd_val_i) & ~$past(imm_i)))
    else $error("clear mask wrong");
  a_test_same: assert property ( // RQ8
    acc && op_i == abx_pkg::OP_ZERO_MINUS_TEST |=>
      res_o[7:0] == $past(rd_val_i) &&
      sreg_o[`ABX_FLAG_Z] == ($past(rd_val_i) == 8'h00))
    else $error("test changed value");
  a_mul_two: assert property ( // RQ9
    acc && op_i == abx_pkg::OP_UNSIGNED_PRODUCT |=> !done_o ##1
      done_o && res_o == $past(rd_val_i, 2) * $past(rr_val_i, 2))
    else $error("product wrong");
  a_ptr_jump: assert property ( // RQ11
    acc && op_i == abx_pkg::OP_POINTER_JUMP |=> busy_o ##1
      done_o && pc_we_o && pc_o == $past(z_ptr_i, 2))
    else $error("pointer jump wrong");
  a_ptr_call: assert property ( // RQ12
    acc && op_i == abx_pkg::OP_POINTER_CALL |=> !done_o [*2] ##1
      done_o && push_o && push_addr_o == $past(pc_i, 3) + 16'h0001)
    else $error("pointer call wrong");
  a_compare_nowr: assert property ( // RQ14
    acc && op_i == abx_pkg::OP_IMMEDIATE_COMPARE |=>
      done_o && !res_we_o)
    else $error("compare stored result");
  a_skip_time: assert property ( // RQ13
    acc && op_i == abx_pkg::OP_EQUAL_SKIP && rd_val_i == rr_val_i &&
      next_two_word_i |=> !done_o [*2] ##1 done_o && pc_we_o &&
      pc_o == $past(pc_i, 3) + 16'h0003)
    else $error("skip timing wrong");
  a_iret_flag: assert property ( // RQ17
    acc && op_i == abx_pkg::OP_INTERRUPT_BACK |=> !done_o [*3] ##1
      done_o && sreg_o[`ABX_FLAG_I])
    else $error("interrupt return wrong");

  c_mul_run: cover property (acc && m_frac ##2 done_o);
  c_call_run: cover property (acc && op_i ==
    abx_pkg::OP_ABSOLUTE_SUBCALL ##4 push_o);
  c_skip_taken: cover property (acc && skip ##1 busy_o);
  c_back2back: cover property (acc ##1 acc);
endmodule
`default_nettype wire

/* File: test/abx_reg_model.sv */
// Register file and return stack model beside the execute unit
`timescale 1ns/1ps
`default_nettype none
module abx_reg_model (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic res_we_i,
  input wire abx_pkg::abx_dst_t res_dst_i,
  input wire logic [15:0] res_i,
  input wire logic push_i,
  input wire logic [15:0] push_addr_i,
  output logic [15:0] byte_o,
  output logic [15:0] word_o,
  output logic [15:0] prod_o,
  output logic [15:0] stack_top_o
);
  // Write-back; a byte keeps all 16 bits so a dirty upper half shows
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      byte_o <= 16'h0;
      word_o <= 16'h0;
      prod_o <= 16'h0;
    end else if (res_we_i) begin
      case (res_dst_i)
        abx_pkg::DST_WORD: word_o <= res_i;
        abx_pkg::DST_PROD: prod_o <= res_i;
        default: byte_o <= res_i;
      endcase
    end
  end
  // One-deep stack: every call in the bench is followed by its return
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stack_top_o <= 16'h0;
    end else if (push_i) begin
      stack_top_o <= push_addr_i;
    end
  end
endmodule
`default_nettype wire

/* File: test/tb_abx_exec_unit.sv */
// Self-checking bench for the execute unit
`timescale 1ns/1ps
`default_nettype none
module tb_abx_exec_unit;
  typedef struct {
    abx_pkg::abx_op_t o;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] i;
    int n;
    int s;
    logic [15:0] r;
    logic [7:0] f;
  } abx_tv_t;
  logic ref_clk, rst, op_valid, next_two, busy, done, res_we, pc_we;
  logic push, pcw;
  abx_pkg::abx_op_t op;
  abx_pkg::abx_dst_t res_dst;
  logic [7:0] rd_val, rr_val, imm, sreg;
  logic [2:0] bit_sel;
  logic [15:0] word, res, pc_new, push_addr, stack_pc, got;
  logic [15:0] m_byte, m_word, m_prod;
  int n_mismatch, checked, cyc;
  // Op, a, b, imm (bit 7 two-word next, 2:0 bit), cycles, where, value, flags
  abx_tv_t tv [42] = '{
    '{abx_pkg::OP_ADD_REG, 8'h0F, 8'h01, 8'h00, 1, 0, 16'h10, 8'h20},
    '{abx_pkg::OP_ADD_REG, 8'h80, 8'h80, 8'h00, 1, 0, 16'h00, 8'h0B},
    '{abx_pkg::OP_ADD_CARRY, 8'h01, 8'h01, 8'h00, 1, 0, 16'h03, 8'h00},
    '{abx_pkg::OP_MINUS_CONSTANT, 8'h10, 8'h00, 8'h01, 1, 0, 16'h0F, 8'h20},
    '{abx_pkg::OP_REG_COMPARE, 8'h00, 8'h01, 8'h00, 1, 0, 16'h0F, 8'h25},
    '{abx_pkg::OP_EXCLUSIVE_DISJUNCTION, 8'hAA, 8'hAA, 8'h00, 1, 0, 16'h00,
      8'h23},
    '{abx_pkg::OP_MINUS_WITH_BORROW, 8'h01, 8'h00, 8'h00, 1, 0, 16'h00,
      8'h02},
    '{abx_pkg::OP_IMMEDIATE_COMPARE, 8'h05, 8'h00, 8'h06, 1, 0, 16'h0,
      8'h25},
    '{abx_pkg::OP_REG_COMPARE_CARRY, 8'h00, 8'h00, 8'h00, 1, 0, 16'h0, 8'h25},
    '{abx_pkg::OP_MINUS_BORROW_CONSTANT, 8'h10, 8'h00, 8'h01, 1, 0, 16'h0E,
      8'h20},
    '{abx_pkg::OP_CONJUNCTION_REG, 8'hF0, 8'h0F, 8'h00, 1, 0, 16'h0, 8'h22},
    '{abx_pkg::OP_CONJUNCTION_CONSTANT, 8'hF0, 8'h00, 8'h80, 1, 0, 16'h80,
      8'h24},
    '{abx_pkg::OP_DISJUNCTION_REG, 8'h00, 8'h00, 8'h00, 1, 0, 16'h0, 8'h22},
    '{abx_pkg::OP_DISJUNCTION_CONSTANT, 8'h01, 8'h00, 8'h80, 1, 0, 16'h81,
      8'h24},
    '{abx_pkg::OP_BIT_CLEAR_MASK, 8'hFF, 8'h00, 8'h0F, 1, 0, 16'hF0, 8'h24},
    '{abx_pkg::OP_BIT_SET_MASK, 8'h00, 8'h00, 8'h01, 1, 0, 16'h01, 8'h20},
    '{abx_pkg::OP_ZERO_MINUS_TEST, 8'h00, 8'h00, 8'h00, 1, 0, 16'h0, 8'h22},
    '{abx_pkg::OP_WORD_ADD_IMMEDIATE, 8'hFF, 8'hFF, 8'h01, 2, 1, 16'h0,
      8'h23},
    '{abx_pkg::OP_WORD_MINUS_IMMEDIATE, 8'h00, 8'h00, 8'h01, 2, 1, 16'hFFFF,
      8'h35},
    '{abx_pkg::OP_UNSIGNED_PRODUCT, 8'h80, 8'h02, 8'h00, 2, 2, 16'h100, 8'h34},
    '{abx_pkg::OP_SIGNED_PRODUCT, 8'h80, 8'h02, 8'h00, 2, 2, 16'hFF00, 8'h35},
    '{abx_pkg::OP_MIXED_SIGN_PRODUCT, 8'h80, 8'h02, 8'h00, 2, 2, 16'hFF00,
      8'h35},
    '{abx_pkg::OP_FRACTION_PRODUCT_UNSIGNED, 8'h80, 8'h02, 8'h00, 2, 2,
      16'h200, 8'h34},
    '{abx_pkg::OP_FRACTION_PRODUCT_SIGNED, 8'h80, 8'h02, 8'h00, 2, 2,
      16'hFE00, 8'h35},
    '{abx_pkg::OP_FRACTION_PRODUCT_MIXED, 8'h80, 8'h02, 8'h00, 2, 2,
      16'hFE00, 8'h35},
    '{abx_pkg::OP_RELATIVE_JUMP, 8'h0, 8'h0, 8'h0, 2, 3, 16'h111, 8'h35},
    '{abx_pkg::OP_POINTER_JUMP, 8'h0, 8'h0, 8'h0, 2, 3, 16'h1234, 8'h35},
    '{abx_pkg::OP_ABSOLUTE_JUMP, 8'h0, 8'h0, 8'h0, 3, 3, 16'h10, 8'h35},
    '{abx_pkg::OP_RELATIVE_SUBCALL, 8'h0, 8'h0, 8'h0, 3, 3, 16'h111, 8'h35},
    '{abx_pkg::OP_SUBROUTINE_BACK, 8'h0, 8'h0, 8'h0, 4, 3, 16'h101, 8'h35},
    '{abx_pkg::OP_POINTER_CALL, 8'h0, 8'h0, 8'h0, 3, 3, 16'h1234, 8'h35},
    '{abx_pkg::OP_INTERRUPT_BACK, 8'h0, 8'h0, 8'h0, 4, 3, 16'h101, 8'hB5},
    '{abx_pkg::OP_ABSOLUTE_SUBCALL, 8'h0, 8'h0, 8'h0, 4, 3, 16'h10, 8'hB5},
    '{abx_pkg::OP_SUBROUTINE_BACK, 8'h0, 8'h0, 8'h0, 4, 3, 16'h102, 8'hB5},
    '{abx_pkg::OP_EQUAL_SKIP, 8'h33, 8'h33, 8'h80, 3, 3, 16'h103, 8'hB5},
    '{abx_pkg::OP_SKIP_ON_BIT_LOW, 8'h0, 8'hF7, 8'h03, 2, 3, 16'h102, 8'hB5},
    '{abx_pkg::OP_SKIP_ON_BIT_HIGH, 8'h0, 8'h08, 8'h83, 3, 3, 16'h103, 8'hB5},
    '{abx_pkg::OP_EQUAL_SKIP, 8'h33, 8'h33, 8'h00, 2, 3, 16'h102, 8'hB5},
    '{abx_pkg::OP_EQUAL_SKIP, 8'h33, 8'h34, 8'h00, 1, 0, 16'h0, 8'hB5},
    '{abx_pkg::OP_SKIP_ON_BIT_HIGH, 8'h0, 8'hF7, 8'h03, 1, 0, 16'h0, 8'hB5},
    '{abx_pkg::OP_SKIP_ON_BIT_LOW, 8'h0, 8'h08, 8'h03, 1, 0, 16'h0, 8'hB5},
    '{abx_pkg::OP_MINUS_REG, 8'h05, 8'h03, 8'h00, 1, 0, 16'h02, 8'h90}
  };
  abx_exec_unit abx_exec_unit_inst (
    .ref_clk_i(ref_clk), .rst_i(rst), .op_valid_i(op_valid), .op_i(op),
    .rd_val_i(rd_val), .rr_val_i(rr_val), .imm_i(imm), .bit_sel_i(bit_sel),
    .word_i(word), .z_ptr_i(16'h1234), .pc_i(16'h0100), .k_i(16'h0010),
    .stack_pc_i(stack_pc), .next_two_word_i(next_two), .busy_o(busy),
    .done_o(done), .res_o(res), .res_we_o(res_we), .res_dst_o(res_dst),
    .sreg_o(sreg), .pc_o(pc_new), .pc_we_o(pc_we), .push_o(push),
    .push_addr_o(push_addr)
  );
  abx_reg_model abx_reg_model_inst (
    .ref_clk_i(ref_clk), .rst_i(rst), .res_we_i(res_we),
    .res_dst_i(res_dst), .res_i(res), .push_i(push),
    .push_addr_i(push_addr), .byte_o(m_byte), .word_o(m_word),
    .prod_o(m_prod), .stack_top_o(stack_pc)
  );
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic final_report;
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // One request held a single cycle, then count cycles until done
  task automatic go(input abx_tv_t t);
    @(posedge ref_clk);
    op <= t.o;
    rd_val <= t.a;
    rr_val <= t.b;
    imm <= t.i;
    word <= {t.a, t.b};
    bit_sel <= t.i[2:0];
    next_two <= t.i[7];
    op_valid <= 1'b1;
    @(posedge ref_clk);
    op_valid <= 1'b0;
    cyc = 1;
    #1;
    // Only multi-cycle operations hold the unit busy after taking
    chk({15'h0, busy}, {15'h0, t.n > 1});
    while (done !== 1'b1 && cyc < 8) begin
      @(posedge ref_clk);
      #1;
      cyc++;
    end
    pcw = pc_we;
    // The model writes back on the edge that closes the done cycle
    @(posedge ref_clk);
    #1;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Cut a hang short well past the expected 1.6 microseconds
  initial begin
    #20000;
    n_mismatch++;
    final_report();
  end
  initial begin
    {rst, op_valid, next_two} = 3'h4;
    {rd_val, rr_val, imm, bit_sel, word} = 43'h0;
    op = abx_pkg::OP_ADD_REG;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (tv[j]) begin
      go(tv[j]);
      case (tv[j].s)
        0: got = m_byte;
        1: got = m_word;
        2: got = m_prod;
        default: got = pc_new;
      endcase
      chk(16'(cyc), 16'(tv[j].n));
      chk(got, tv[j].r);
      chk({8'h00, sreg}, {8'h00, tv[j].f});
      chk({15'h0, pcw}, {15'h0, tv[j].s == 3});
      $display("test %0d done", j);
    end
    final_report();
  end
endmodule
`default_nettype wire
